//--- logic/debug_serial_cmd.sv
// Serial debug command interpreter: fill, go, nop, pc sync, control and debug registers
`timescale 1ns/1ps
`default_nettype none
`include "debug_serial_defines.svh"

module debug_serial_cmd (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serialDebugClk,
  input wire logic serialDataIn,
  output logic serialDataOut,
  input wire logic cpuHalted,
  output logic resumeReq,
  output logic pcSyncReq,
  input wire logic cpuPcFetch,
  input wire logic [31:0] cpuPcAddr,
  output debug_serial_pkg::trace_t traceOut,
  input wire logic wrDone,
  input wire logic [31:0] wrAddr,
  input wire logic [1:0] wrSize,
  output logic memReq,
  output debug_serial_pkg::fill_req_t memReqInfo,
  input wire logic memAck,
  input wire logic memErr,
  output logic cregReq,
  output debug_serial_pkg::creg_req_t cregReqInfo,
  input wire logic cregAck,
  input wire logic cregErr,
  input wire logic [31:0] cregRdata,
  input wire logic bkptStateSet,
  input wire logic [3:0] bkptStateVal,
  output logic [31:0] debugConfigStatus
);

  // Link synchronisers and frame assembly
  logic [1:0] clkSync_q;
  logic [1:0] dinSync_q;
  logic clkPrev_q;
  logic [4:0] bitCnt_q;
  logic [15:0] rxShift_q;
  logic [16:0] txShift_q;
  logic wordValid_q;
  logic [15:0] word_q;
  // Command engine
  debug_serial_pkg::cmd_state_t state_q;
  logic [16:0] resp_q;
  logic [16:0] respLow_q;
  logic respLowValid_q;
  logic [63:0] args_q;
  logic [1:0] argCnt_q;
  logic [1:0] fillSize_q;
  logic fillOk_q;
  logic [31:0] heldAddr_q;
  logic [31:0] csr_q;
  logic resume_q;
  logic pcSyncReq_q;
  logic [31:0] pcCap_q;
  logic [2:0] nibCnt_q;
  debug_serial_pkg::trace_t trace_q;
  logic memReq_q;
  debug_serial_pkg::fill_req_t memInfo_q;
  logic cregReq_q;
  debug_serial_pkg::creg_req_t cregInfo_q;

  // Edges of the sampled serial clock; bit taken on the rising edge
  wire sdRise = clkSync_q[1] & ~clkPrev_q;
  wire frameEnd = sdRise & (bitCnt_q == `FRAME_LAST_BIT);
  wire [15:0] rxWord = {rxShift_q[14:0], dinSync_q[1]};

  // Command decode of the received word
  wire idleCmd = wordValid_q & (state_q == debug_serial_pkg::ST_IDLE);
  wire [1:0] cmdSize = word_q[7:6];
  wire sizeOk = (word_q[5:4] == 2'h0) & (cmdSize != 2'h3);
  wire isFill = (word_q[15:8] == `OPC_FILL_HI) & (word_q[3:0] == `OPC_LOW_ZERO) & sizeOk;
  wire isWrite = (word_q[15:8] == `OPC_WRITE_HI);
  wire isGo = (word_q == `OPC_GO);
  wire isNop = (word_q == `OPC_NOP);
  wire isSync = (word_q == `OPC_PC_TRACE_SYNC_CMD);
  wire isRcreg = (word_q == `OPC_CTRL_REG_READ_CMD);
  wire isWcreg = (word_q == `OPC_CTRL_REG_WRITE_CMD);
  wire isDregRd = (word_q[15:12] == `OPC_DREG_TOP) & (word_q[11:8] == `OPC_DREG_RD)
                  & (word_q[7:5] == `OPC_DREG_FIX);
  wire isDregWr = (word_q[15:12] == `OPC_DREG_TOP) & (word_q[11:8] == `OPC_DREG_WR)
                  & (word_q[7:5] == `OPC_DREG_FIX);
  wire dregSelOk = (word_q[4:0] == `DREG_SEL_CSR);

  // Fill data: a byte in the low eight bits, a word, or a long upper word first
  wire [31:0] fillData = (fillSize_q == `SIZE_LONG) ? args_q[31:0] :
                         (fillSize_q == `SIZE_WORD) ? {16'h0000, args_q[15:0]} :
                         {24'h000000, args_q[7:0]};
  wire [1:0] fillWords = (fillSize_q == `SIZE_LONG) ? 2'd2 : 2'd1;
  wire [31:0] fillIncr = (memInfo_q.size == `SIZE_LONG) ? 32'h00000004 :
                         (memInfo_q.size == `SIZE_WORD) ? 32'h00000002 : 32'h00000001;
  wire [31:0] wrIncr = (wrSize == `SIZE_LONG) ? 32'h00000004 :
                       (wrSize == `SIZE_WORD) ? 32'h00000002 : 32'h00000001;

  // Control selector map
  wire [11:0] rcSel = args_q[11:0];
  wire [11:0] wcSel = args_q[43:32];
  // The write selector is judged once all operands are in, in the bus state
  wire [11:0] cSel = (state_q == debug_serial_pkg::ST_WC_BUS) ? wcSel : rcSel;
  wire cSelOk = (cSel == `CR_CACHE) | ((cSel >= `CR_ACCESS_LO) & (cSel <= `CR_ACCESS_HI))
                | (cSel == `CR_VECTOR) | ((cSel >= `CR_MAC_LO) & (cSel <= `CR_MAC_HI))
                | (cSel == `CR_STATUS) | (cSel == `CR_PC) | (cSel == `CR_RAM0)
                | (cSel == `CR_RAM1) | (cSel == `CR_MODBASE);

  // Breakpoint state clear on a config/status read
  wire [3:0] breakpoint_state = csr_q[`BREAKPOINT_STATE_MSB:`BREAKPOINT_STATE_LSB];
  wire csrRead = idleCmd & isDregRd & dregSelOk;
  wire bstatClr = csrRead & ((breakpoint_state == `BREAKPOINT_STATE_L2_TRIG) | (breakpoint_state == `BREAKPOINT_STATE_L1_TRIG));
  wire [1:0] btbCfg = csr_q[`BTB_MSB:`BTB_LSB];
  wire [1:0] btbEff = (btbCfg == 2'h3) ? 2'h2 : btbCfg;
  wire [2:0] nibLast = {btbEff, 1'b1} + 3'd2;

  // Two-flop synchronisers for the serial clock and data pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync_q <= 2'b00;
      dinSync_q <= 2'b00;
      clkPrev_q <= 1'b0;
    end else begin
      clkSync_q <= {clkSync_q[0], serialDebugClk};
      dinSync_q <= {dinSync_q[0], serialDataIn};
      clkPrev_q <= clkSync_q[1];
    end
  end

  // Frame shifter: data in and out move on each serial clock rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q <= 5'd0;
      rxShift_q <= 16'h0000;
      txShift_q <= `RESP_NOT_READY;
      wordValid_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      // A word arriving while the upper half of a long answer leaves is dropped, so the lower half goes next
      wordValid_q <= frameEnd & ~respLowValid_q;
      if (sdRise) begin
        rxShift_q <= rxWord;
        bitCnt_q <= frameEnd ? 5'd0 : bitCnt_q + 5'd1;
        txShift_q <= {txShift_q[15:0], 1'b0};
      end else if (bitCnt_q == 5'd0) begin
        // Between frames the shifter follows the answer, so it leaves on the very next shift
        txShift_q <= resp_q;
      end
      if (frameEnd) begin
        word_q <= rxWord;
      end
    end
  end

  // Command engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= debug_serial_pkg::ST_IDLE;
      resp_q <= `RESP_NOT_READY;
      respLow_q <= `RESP_NOT_READY;
      respLowValid_q <= 1'b0;
      args_q <= 64'h0;
      argCnt_q <= 2'd0;
      fillSize_q <= `SIZE_BYTE;
      fillOk_q <= 1'b0;
      heldAddr_q <= 32'h00000000;
      resume_q <= 1'b0;
      pcSyncReq_q <= 1'b0;
      pcCap_q <= 32'h00000000;
      nibCnt_q <= 3'd0;
      trace_q <= '0;
      memReq_q <= 1'b0;
      memInfo_q <= '0;
      cregReq_q <= 1'b0;
      cregInfo_q <= '0;
    end else begin
      resume_q <= 1'b0;
      // Answer moves to the shifter at frame end; a pending low word follows
      if (frameEnd) begin
        resp_q <= respLowValid_q ? respLow_q : `RESP_NOT_READY;
        respLowValid_q <= 1'b0;
      end
      // A memory write seeds the held address with the address after it unless a fill completes in that cycle
      if (wrDone) begin
        heldAddr_q <= wrAddr + wrIncr;
      end
      if (wordValid_q) begin
        args_q <= {args_q[47:0], word_q};
      end
      case (state_q)
        debug_serial_pkg::ST_IDLE: begin
          argCnt_q <= 2'd0;
          if (wordValid_q) begin
            fillOk_q <= isWrite | isNop | (isFill & fillOk_q);
            if (isFill && fillOk_q) begin
              fillSize_q <= cmdSize;
              state_q <= debug_serial_pkg::ST_FILL_DATA;
            end else if (isFill) begin
              resp_q <= `RESP_ILLEGAL;
            end else if (isGo) begin
              resume_q <= cpuHalted;
              resp_q <= `RESP_DONE;
            end else if (isNop) begin
              resp_q <= `RESP_DONE;
            end else if (isSync) begin
              pcSyncReq_q <= 1'b1;
              state_q <= debug_serial_pkg::ST_SYNC_WAIT;
            end else if (isRcreg) begin
              state_q <= debug_serial_pkg::ST_RC_ARG;
            end else if (isWcreg) begin
              state_q <= debug_serial_pkg::ST_WC_ARG;
            end else if (isDregRd && dregSelOk) begin
              resp_q <= {1'b0, csr_q[31:16]};
              respLow_q <= {1'b0, csr_q[15:0]};
              respLowValid_q <= 1'b1;
            end else if (isDregWr) begin
              state_q <= debug_serial_pkg::ST_WD_ARG;
            end else if (isDregRd) begin
              resp_q <= `RESP_ILLEGAL;
            end
          end
        end
        debug_serial_pkg::ST_FILL_DATA: begin
          if (wordValid_q) begin
            argCnt_q <= argCnt_q + 2'd1;
            if (argCnt_q + 2'd1 == fillWords) begin
              state_q <= debug_serial_pkg::ST_FILL_BUS;
            end
          end
        end
        debug_serial_pkg::ST_FILL_BUS: begin
          if (!memReq_q) begin
            memReq_q <= 1'b1;
            memInfo_q <= '{addr: heldAddr_q, data: fillData, size: fillSize_q};
          end else if (memAck || memErr) begin
            memReq_q <= 1'b0;
            heldAddr_q <= heldAddr_q + fillIncr;
            resp_q <= memErr ? `RESP_BUS_ERR : `RESP_DONE;
            state_q <= debug_serial_pkg::ST_IDLE;
          end
        end
        debug_serial_pkg::ST_RC_ARG: begin
          if (wordValid_q) begin
            argCnt_q <= argCnt_q + 2'd1;
          end
          if (argCnt_q == 2'd2) begin
            if (cSelOk) begin
              cregReq_q <= 1'b1;
              cregInfo_q <= '{write: 1'b0, sel: rcSel, wdata: 32'h00000000};
              state_q <= debug_serial_pkg::ST_RC_BUS;
            end else begin
              resp_q <= `RESP_BUS_ERR;
              state_q <= debug_serial_pkg::ST_IDLE;
            end
          end
        end
        debug_serial_pkg::ST_RC_BUS: begin
          if (cregAck || cregErr) begin
            cregReq_q <= 1'b0;
            resp_q <= cregErr ? `RESP_BUS_ERR : {1'b0, cregRdata[31:16]};
            respLow_q <= {1'b0, cregRdata[15:0]};
            respLowValid_q <= ~cregErr;
            state_q <= debug_serial_pkg::ST_IDLE;
          end
        end
        debug_serial_pkg::ST_WC_ARG: begin
          if (wordValid_q) begin
            argCnt_q <= argCnt_q + 2'd1;
            if (argCnt_q == 2'd3) begin
              state_q <= debug_serial_pkg::ST_WC_BUS;
            end
          end
        end
        debug_serial_pkg::ST_WC_BUS: begin
          if (!cregReq_q && !cSelOk) begin
            resp_q <= `RESP_BUS_ERR;
            state_q <= debug_serial_pkg::ST_IDLE;
          end else if (!cregReq_q) begin
            cregReq_q <= 1'b1;
            cregInfo_q <= '{write: 1'b1, sel: wcSel, wdata: args_q[31:0]};
          end else if (cregAck || cregErr) begin
            cregReq_q <= 1'b0;
            resp_q <= cregErr ? `RESP_BUS_ERR : `RESP_DONE;
            state_q <= debug_serial_pkg::ST_IDLE;
          end
        end
        debug_serial_pkg::ST_WD_ARG: begin
          if (wordValid_q) begin
            argCnt_q <= argCnt_q + 2'd1;
            if (argCnt_q == 2'd1) begin
              resp_q <= `RESP_DONE;
              state_q <= debug_serial_pkg::ST_IDLE;
            end
          end
        end
        debug_serial_pkg::ST_SYNC_WAIT: begin
          if (cpuPcFetch) begin
            pcSyncReq_q <= 1'b0;
            pcCap_q <= cpuPcAddr;
            trace_q <= '{status: `TRACE_BRANCH, data: 4'h0};
            state_q <= debug_serial_pkg::ST_SYNC_MARK;
          end
        end
        debug_serial_pkg::ST_SYNC_MARK: begin
          trace_q <= '{status: `TRACE_MARK_BASE + {2'b00, btbEff}, data: 4'h0};
          nibCnt_q <= 3'd0;
          state_q <= debug_serial_pkg::ST_SYNC_ADDR;
        end
        debug_serial_pkg::ST_SYNC_ADDR: begin
          trace_q <= '{status: `TRACE_IDLE, data: pcCap_q[3:0]};
          pcCap_q <= {4'h0, pcCap_q[31:4]};
          nibCnt_q <= nibCnt_q + 3'd1;
          if (nibCnt_q == nibLast) begin
            resp_q <= `RESP_DONE;
            state_q <= debug_serial_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= debug_serial_pkg::ST_IDLE;
        end
      endcase
      if (state_q != debug_serial_pkg::ST_SYNC_ADDR && state_q != debug_serial_pkg::ST_SYNC_MARK
          && !(state_q == debug_serial_pkg::ST_SYNC_WAIT && cpuPcFetch)) begin
        trace_q <= '{status: `TRACE_IDLE, data: 4'h0};
      end
    end
  end

  // Config/status: breakpoint update wins over a read clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_q <= `CSR_RESET;
    end else if (state_q == debug_serial_pkg::ST_WD_ARG && wordValid_q && argCnt_q == 2'd1
                 && args_q[20:16] == `DREG_SEL_CSR) begin
      csr_q <= {args_q[15:0], word_q};
    end else if (bkptStateSet) begin
      csr_q[`BREAKPOINT_STATE_MSB:`BREAKPOINT_STATE_LSB] <= bkptStateVal;
    end else if (bstatClr) begin
      csr_q[`BREAKPOINT_STATE_MSB:`BREAKPOINT_STATE_LSB] <= 4'h0;
    end
  end

  // Outputs come straight from flops
  assign serialDataOut = txShift_q[16];
  assign resumeReq = resume_q;
  assign pcSyncReq = pcSyncReq_q;
  assign traceOut = trace_q;
  assign memReq = memReq_q;
  assign memReqInfo = memInfo_q;
  assign cregReq = cregReq_q;
  assign cregReqInfo = cregInfo_q;
  assign debugConfigStatus = csr_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence fetchTaken;
    (state_q == debug_serial_pkg::ST_SYNC_WAIT) && cpuPcFetch;
  endsequence
  sequence branchThenMark;
    (traceOut.status == `TRACE_BRANCH) ##1 (traceOut.status >= `TRACE_MARK_BASE);
  endsequence

  AST_FILL_ILLEGAL: assert property (idleCmd && isFill && !fillOk_q |=>
    resp_q == `RESP_ILLEGAL && state_q == debug_serial_pkg::ST_IDLE && !memReq)
    else $error("Fill without prior write was not refused");
  AST_FILL_INCR: assert property (memReq && (memAck || memErr) && !wrDone |=>
    heldAddr_q == $past(heldAddr_q) + $past(fillIncr))
    else $error("Held address did not advance by the operand size");
  AST_FILL_BERR: assert property (memReq && memErr |=> resp_q == `RESP_BUS_ERR)
    else $error("Fill bus error answer wrong");
  AST_GO_IGNORED: assert property (idleCmd && isGo && !cpuHalted |=> !resumeReq)
    else $error("Go acted while running");
  AST_GO_RESUME: assert property (idleCmd && isGo && cpuHalted |=>
    resumeReq && resp_q == `RESP_DONE ##1 !resumeReq)
    else $error("Go while halted did not pulse resume");
  AST_NOP_STILL: assert property (idleCmd && isNop && !wrDone |=>
    $stable(heldAddr_q) && resp_q == `RESP_DONE && fillOk_q)
    else $error("Nop changed state or answered wrong");
  AST_SYNC_ORDER: assert property (fetchTaken |=> branchThenMark)
    else $error("Pc sync trace order wrong");
  AST_WC_BERR: assert property (state_q == debug_serial_pkg::ST_WC_BUS && cregReq && cregErr |=>
    resp_q == `RESP_BUS_ERR && !cregReq)
    else $error("Control write bus error answer wrong");
  AST_BREAKPOINT_STATE_CLR: assert property (bstatClr && !bkptStateSet |=>
    debugConfigStatus[`BREAKPOINT_STATE_MSB:`BREAKPOINT_STATE_LSB] == 4'h0)
    else $error("Breakpoint state not cleared by read");
  AST_DREG_BAD: assert property (idleCmd && isDregRd && !dregSelOk |=> resp_q == `RESP_ILLEGAL)
    else $error("Reserved debug selector accepted");

endmodule

`default_nettype wire

//--- inc/debug_serial_defines.svh
// Constants of the serial debug command interpreter
`ifndef DEBUG_SERIAL_DEFINES_SVH
`define DEBUG_SERIAL_DEFINES_SVH

// Serial frame: one status bit then sixteen data bits
`define FRAME_LAST_BIT 5'd16
`define FRAME_W 17

// Command words and opcode fields
`define OPC_FILL_HI 8'h1C
`define OPC_WRITE_HI 8'h18
`define OPC_GO 16'h0C00
`define OPC_NOP 16'h0000
`define OPC_PC_TRACE_SYNC_CMD 16'h0001
`define OPC_CTRL_REG_READ_CMD 16'h2980
`define OPC_CTRL_REG_WRITE_CMD 16'h2880
`define OPC_DREG_TOP 4'h2
`define OPC_DREG_RD 4'hD
`define OPC_DREG_WR 4'hC
`define OPC_DREG_FIX 3'h4
`define OPC_LOW_ZERO 4'h0
`define DREG_SEL_CSR 5'h00

// Size field, bits 7:6 of a sized command
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2

// Answers: status bit then data
`define RESP_DONE 17'h0FFFF
`define RESP_BUS_ERR 17'h10001
`define RESP_ILLEGAL 17'h1FFFF
`define RESP_NOT_READY 17'h10000

// Config/status register fields
`define CSR_RESET 32'h00000000
`define BREAKPOINT_STATE_MSB 31
`define BREAKPOINT_STATE_LSB 28
`define BTB_MSB 9
`define BTB_LSB 8
`define BREAKPOINT_STATE_L1_TRIG 4'h2
`define BREAKPOINT_STATE_L2_TRIG 4'h6

// Trace status codes
`define TRACE_IDLE 4'h0
`define TRACE_BRANCH 4'h5
`define TRACE_MARK_BASE 4'h9

// Control register selectors
`define CR_CACHE 12'h002
`define CR_ACCESS_LO 12'h004
`define CR_ACCESS_HI 12'h007
`define CR_VECTOR 12'h801
`define CR_MAC_LO 12'h804
`define CR_MAC_HI 12'h806
`define CR_STATUS 12'h80E
`define CR_PC 12'h80F
`define CR_RAM0 12'hC04
`define CR_RAM1 12'hC05
`define CR_MODBASE 12'hC0F

`endif

//--- inc/debug_serial_pkg.sv
// Types of the serial debug command interpreter
package debug_serial_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0] size;
  } fill_req_t;

  typedef struct packed {
    logic write;
    logic [11:0] sel;
    logic [31:0] wdata;
  } creg_req_t;

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] data;
  } trace_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FILL_DATA, ST_FILL_BUS, ST_RC_ARG, ST_RC_BUS, ST_WC_ARG, ST_WC_BUS,
    ST_WD_ARG, ST_SYNC_WAIT, ST_SYNC_MARK, ST_SYNC_ADDR
  } cmd_state_t;

endpackage

//--- testbench/serial_host_model.sv
// Host model of the serial debug link: shifts 17-bit frames in and out
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  input wire logic sys_clk,
  output logic serialDebugClk,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  initial begin
    serialDebugClk = 1'b0;
    serialDataIn = 1'b0;
  end

  // One frame, status bit first; clock idles low between frames
  task automatic shift(input logic [15:0] word, output logic [16:0] rx);
    logic [16:0] tx;
    tx = {1'b0, word};
    for (int i = 16; i >= 0; i--) begin
      @(negedge sys_clk);
      serialDataIn = tx[i];
      repeat (15) @(negedge sys_clk);
      serialDebugClk = 1'b1;
      rx[i] = serialDataOut;
      repeat (16) @(negedge sys_clk);
      serialDebugClk = 1'b0;
    end
    serialDataIn = ~tx[0]; // Released line must not look held
  endtask
endmodule

`default_nettype wire

//--- testbench/tb_debug_serial_cmd.sv
// Testbench of the serial debug command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "debug_serial_defines.svh"

module tb_debug_serial_cmd;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic serialDebugClk, serialDataIn, serialDataOut, resumeReq, pcSyncReq, memReq, cregReq;
  logic cpuHalted = 1'b0;
  logic cpuPcFetch = 1'b0;
  logic wrDone = 1'b0;
  logic memAck = 1'b0;
  logic memErr = 1'b0;
  logic cregAck = 1'b0;
  logic cregErr = 1'b0;
  logic bkptStateSet = 1'b0;
  logic [3:0] bkptStateVal = 4'h0;
  logic [1:0] wrSize = 2'h0;
  logic [31:0] cpuPcAddr = 32'h0;
  logic [31:0] wrAddr = 32'h0;
  logic [31:0] debugConfigStatus;
  logic memErrMode = 1'b0;
  logic cregErrMode = 1'b0;
  debug_serial_pkg::trace_t traceOut;
  debug_serial_pkg::fill_req_t memReqInfo, lastFill;
  debug_serial_pkg::creg_req_t cregReqInfo, lastCreg;
  int n_fail = 0;
  int num_checks = 0;
  int nResume = 0;
  int nMem = 0;
  int nCreg = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  serial_host_model host (.sys_clk(sys_clk), .serialDebugClk(serialDebugClk), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut));

  debug_serial_cmd dut (.sys_clk(sys_clk), .rst_n(rst_n), .serialDebugClk(serialDebugClk),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .cpuHalted(cpuHalted), .resumeReq(resumeReq),
    .pcSyncReq(pcSyncReq), .cpuPcFetch(cpuPcFetch), .cpuPcAddr(cpuPcAddr), .traceOut(traceOut),
    .wrDone(wrDone), .wrAddr(wrAddr), .wrSize(wrSize), .memReq(memReq), .memReqInfo(memReqInfo),
    .memAck(memAck), .memErr(memErr), .cregReq(cregReq), .cregReqInfo(cregReqInfo), .cregAck(cregAck),
    .cregErr(cregErr), .cregRdata(32'hCAFEF00D), .bkptStateSet(bkptStateSet), .bkptStateVal(bkptStateVal),
    .debugConfigStatus(debugConfigStatus));

  // Memory and control-register responders answer one cycle after a request
  always @(negedge sys_clk) begin
    memAck <= memReq && !memAck && !memErr && !memErrMode;
    memErr <= memReq && !memAck && !memErr && memErrMode;
    cregAck <= cregReq && !cregAck && !cregErr && !cregErrMode;
    cregErr <= cregReq && !cregAck && !cregErr && cregErrMode;
    if (memReq && !memAck && !memErr) begin
      lastFill <= memReqInfo;
      nMem++;
    end
    if (cregReq && !cregAck && !cregErr) begin
      lastCreg <= cregReqInfo;
      nCreg++;
    end
  end

  // Pulse counter and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (resumeReq === 1'b1) nResume++;
    if (cycles == 60000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic send(input logic [15:0] w);
    logic [16:0] rx;
    host.shift(w, rx);
  endtask

  task automatic xfer(input logic [15:0] w, input logic [16:0] exp, input string nm);
    logic [16:0] rx;
    host.shift(w, rx);
    chk(nm, {15'h0, exp}, {15'h0, rx});
  endtask

  task automatic t_fill;
    send(16'h1C40);
    xfer(`OPC_NOP, `RESP_ILLEGAL, "fill unprimed");
    chk("fill writes", 32'h0, nMem);
    @(negedge sys_clk);
    wrDone = 1'b1;
    wrAddr = 32'h00001000;
    wrSize = `SIZE_WORD;
    @(negedge sys_clk);
    wrDone = 1'b0;
    send(16'h1C40);
    send(16'hBEEF);
    xfer(16'h1C80, `RESP_DONE, "fill word");
    chk("word addr", 32'h00001002, lastFill.addr);
    chk("word data", 32'h0000BEEF, lastFill.data[15:0]);
    send(16'h1234);
    send(16'h5678);
    xfer(`OPC_NOP, `RESP_DONE, "fill long");
    chk("long addr", 32'h00001004, lastFill.addr);
    chk("long data", 32'h12345678, lastFill.data);
    chk("long size", 32'h2, {30'h0, lastFill.size});
    memErrMode = 1'b1;
    xfer(16'h1C00, `RESP_DONE, "nop answer");
    send(16'h00AB);
    xfer(`OPC_NOP, `RESP_BUS_ERR, "fill error");
    chk("byte addr", 32'h00001008, lastFill.addr);
    memErrMode = 1'b0;
    $display("fill test done");
  endtask

  task automatic t_go;
    send(`OPC_GO);
    xfer(`OPC_NOP, `RESP_DONE, "go running");
    chk("resume ignored", 32'h0, nResume);
    cpuHalted = 1'b1;
    send(`OPC_GO);
    xfer(16'h1C40, `RESP_DONE, "go halted");
    chk("resume pulses", 32'h1, nResume);
    xfer(`OPC_NOP, `RESP_ILLEGAL, "fill after go");
    cpuHalted = 1'b0;
    $display("go test done");
  endtask

  task automatic t_creg;
    send(`OPC_CTRL_REG_READ_CMD);
    send(16'h0000);
    send(16'h0801);
    xfer(`OPC_NOP, 17'h0CAFE, "creg hi");
    chk("creg rd sel", 32'h00000801, {19'h0, lastCreg.write, lastCreg.sel});
    xfer(`OPC_NOP, 17'h0F00D, "creg lo");
    send(`OPC_CTRL_REG_READ_CMD);
    send(16'h0000);
    send(16'h0003);
    xfer(`OPC_NOP, `RESP_BUS_ERR, "creg unmapped");
    chk("creg cycles", 32'h1, nCreg);
    for (int e = 0; e < 2; e++) begin
      cregErrMode = e[0];
      send(`OPC_CTRL_REG_WRITE_CMD);
      send(16'h0000);
      send(16'h0C04);
      send(16'hDEAD);
      send(16'hBEEF);
      xfer(`OPC_NOP, e ? `RESP_BUS_ERR : `RESP_DONE, "creg write");
      chk("creg wr sel", 32'h00001C04, {19'h0, lastCreg.write, lastCreg.sel});
      chk("creg wdata", 32'hDEADBEEF, lastCreg.wdata);
    end
    cregErrMode = 1'b0;
    $display("control register test done");
  endtask

  task automatic t_dreg;
    send(16'h2C80);
    send(16'h1234);
    send(16'h0200);
    xfer(`OPC_NOP, `RESP_DONE, "dreg write");
    chk("csr write", 32'h12340200, debugConfigStatus);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) begin
        @(negedge sys_clk);
        bkptStateSet = 1'b1;
        bkptStateVal = (i == 1) ? `BREAKPOINT_STATE_L1_TRIG : `BREAKPOINT_STATE_L2_TRIG;
        @(negedge sys_clk);
        bkptStateSet = 1'b0;
      end
      send(16'h2D80);
      xfer(`OPC_NOP, {1'b0, (i == 0) ? 4'h1 : bkptStateVal, 12'h234}, "csr hi");
      xfer(`OPC_NOP, 17'h00200, "csr lo");
      chk("breakpoint_state", (i == 0) ? 32'h12340200 : 32'h02340200, debugConfigStatus);
    end
    send(16'h2D81);
    xfer(`OPC_NOP, `RESP_ILLEGAL, "dreg reserved");
    $display("debug register test done");
  endtask

  task automatic t_sync;
    send(`OPC_PC_TRACE_SYNC_CMD);
    chk("sync pending", 32'h1, {31'h0, pcSyncReq});
    @(negedge sys_clk);
    cpuPcFetch = 1'b1;
    cpuPcAddr = 32'h89ABCDEF;
    @(negedge sys_clk);
    cpuPcFetch = 1'b0;
    repeat (4) if (traceOut.status !== `TRACE_BRANCH) @(negedge sys_clk);
    chk("trace branch", 32'h5, {28'h0, traceOut.status});
    chk("sync cleared", 32'h0, {31'h0, pcSyncReq});
    @(negedge sys_clk);
    chk("trace marker", 32'hB, {28'h0, traceOut.status});
    @(negedge sys_clk);
    chk("first nibble", 32'hF, {28'h0, traceOut.data});
    for (int k = 1; k < 8; k++) begin
      @(negedge sys_clk);
      chk("pc nibble", (32'h89ABCDEF >> (4 * k)) & 32'h0000000F, {28'h0, traceOut.data});
    end
    repeat (12) @(negedge sys_clk);
    xfer(`OPC_NOP, `RESP_DONE, "sync done");
    $display("pc sync test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    chk("out in reset", 32'h1, {31'h0, serialDataOut});
    chk("csr reset", 32'h0, debugConfigStatus);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_fill();
    t_go();
    t_creg();
    t_dreg();
    t_sync();
    results();
  end
endmodule

`default_nettype wire
